// ### rtl/dmc_pkg.sv
// Shared constants, operation codes and saturation helpers of the datapath.
package dmc_pkg;

  // ==========================================================
  // Widths and counts
  // ==========================================================
  localparam int DMC_NREG = 8;
  localparam int DMC_RW = 32;
  localparam int DMC_HW = 16;
  localparam int DMC_AW = 40;
  localparam int DMC_NVID = 4;
  localparam logic [31:0] DMC_REG_RST = 32'h0000_0000;
  localparam logic [39:0] DMC_ACC_RST = 40'h00_0000_0000;
  localparam logic [40:0] DMC_RND_HALF = 41'h000_0000_8000;

  // ==========================================================
  // Operation codes
  // ==========================================================
  localparam logic [4:0] OP_ADD = 5'h00;
  localparam logic [4:0] OP_SUB = 5'h01;
  localparam logic [4:0] OP_AND = 5'h02;
  localparam logic [4:0] OP_OR = 5'h03;
  localparam logic [4:0] OP_XOR = 5'h04;
  localparam logic [4:0] OP_ADD2 = 5'h05;
  localparam logic [4:0] OP_QUAD = 5'h06;
  localparam logic [4:0] OP_POPC = 5'h07;
  localparam logic [4:0] OP_MUL32 = 5'h08;
  localparam logic [4:0] OP_DIVS = 5'h09;
  localparam logic [4:0] OP_RND16 = 5'h0a;
  localparam logic [4:0] OP_SIGNB = 5'h0b;
  localparam logic [4:0] OP_NORM = 5'h0c;
  localparam logic [4:0] OP_SHIFT = 5'h0d;
  localparam logic [4:0] OP_ROT = 5'h0e;
  localparam logic [4:0] OP_EXTR = 5'h0f;
  localparam logic [4:0] OP_DEP = 5'h10;
  localparam logic [4:0] OP_MIN = 5'h11;
  localparam logic [4:0] OP_MAX = 5'h12;
  localparam logic [4:0] OP_VSRCH = 5'h13;
  localparam logic [4:0] OP_VADD8 = 5'h14;
  localparam logic [4:0] OP_VAVG8 = 5'h15;
  localparam logic [4:0] OP_ABSACC = 5'h16;
  localparam logic [4:0] OP_ALIGN = 5'h17;
  localparam logic [4:0] OP_PACK = 5'h18;
  localparam logic [4:0] OP_MAC = 5'h19;
  localparam logic [4:0] OP_MLOAD = 5'h1a;
  localparam logic [4:0] OP_MREAD = 5'h1b;

  // ==========================================================
  // Saturation of a signed 41-bit value to narrower widths
  // ==========================================================
  function automatic logic [15:0] dmc_sat16(input logic [40:0] v);
    if (!v[40] && v[39:15] != 25'h0) dmc_sat16 = 16'h7fff;
    else if (v[40] && v[39:15] != 25'h1ffffff) dmc_sat16 = 16'h8000;
    else dmc_sat16 = v[15:0];
  endfunction : dmc_sat16

  function automatic logic [31:0] dmc_sat32(input logic [40:0] v);
    if (!v[40] && v[39:31] != 9'h0) dmc_sat32 = 32'h7fff_ffff;
    else if (v[40] && v[39:31] != 9'h1ff) dmc_sat32 = 32'h8000_0000;
    else dmc_sat32 = v[31:0];
  endfunction : dmc_sat32

endpackage : dmc_pkg

// ### rtl/dmc_mac_unit.sv
// One multiply-accumulate unit with a 40-bit accumulator.
`timescale 1ns/1ps
module dmc_mac_unit
  import dmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic load_in,
  input wire logic signed_in,
  input wire logic rnd_in,
  input wire logic sat_in,
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  output logic [39:0] acc_out,
  output logic [15:0] res16_out
);

  // ==========================================================
  // Product and accumulation
  // ==========================================================
  logic [39:0] acc_r;
  logic [39:0] acc_nxt;
  logic [40:0] prod;
  logic [40:0] sum;
  logic [40:0] rnd;
  logic [40:0] hi;

  always_comb
  begin
    if (signed_in)
      prod = 41'($signed(a_in) * $signed(b_in));
    else
      prod = {9'h0, 32'(a_in * b_in)};
    sum = load_in ? prod : {acc_r[39], acc_r} + prod;
    acc_nxt = acc_r;
    if (en_in)
    begin
      if (sat_in && sum[40] != sum[39])
        acc_nxt = sum[40] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff;
      else
        acc_nxt = sum[39:0];
    end
    rnd = {acc_r[39], acc_r} + (rnd_in ? DMC_RND_HALF : 41'h0);
    hi = {{16{rnd[40]}}, rnd[40:16]};
    res16_out = sat_in ? dmc_sat16(hi) : hi[15:0];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in) acc_r <= DMC_ACC_RST;
    else acc_r <= acc_nxt; // [RQ3] [RQ4] [RQ16]
  end

  assign acc_out = acc_r;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_mac_accum: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    en_in && !load_in && !sat_in && signed_in |=> acc_r ==
    $past(acc_r) + 40'($signed($past(a_in)) * $signed($past(b_in)))) // [RQ3]
    else $error("accumulator did not add the product");
  chk_mac_satur: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    en_in && sat_in && sum[40] && !sum[39] |=>
    acc_r == 40'h80_0000_0000) // [RQ16]
    else $error("accumulator did not clamp negative overflow");

endmodule : dmc_mac_unit

// ### rtl/dmc_datapath.sv
// Dual multiply-accumulate compute datapath with register file and ALUs.
// Functional notes
// RQ1 - Eight 32-bit registers plus an instruction constant feed every op.
// RQ2 - Sixteen-bit ops pick the high or low half of any register.
// RQ3 - Each MAC multiplies 16 by 16 bits per cycle into its 40-bit acc.
// RQ4 - MACs take signed or unsigned operands with rounding and saturation.
// RQ5 - Two multipliers and two accumulators work in the same cycle.
// RQ6 - Two 40-bit ALUs and four byte-wide video ALUs are provided.
// RQ7 - Operands of 8, 16 or 32 bits are taken from the register file.
// RQ8 - ALUs run add, subtract and logic ops on 16 or 32 bits.
// RQ9 - ALUs do extract, popcount, mod 2^32 multiply, divide step, round, sign.
// RQ10 - Video ops align, pack, clip-add, average and subtract-abs-accumulate.
// RQ11 - Compare-and-select and vector search are supported.
// RQ12 - One ALU runs independent high and low half operations at once.
// RQ13 - Both ALUs together give four 16-bit results in one operation.
// RQ14 - The 40-bit shifter shifts, rotates, normalises, extracts, deposits.
// RQ15 - Results are written back before the next op reads, with no stalls.
// RQ16 - Saturated overflow gives the most positive or negative value; the QUAD sums and ABSACC ignore sat_in and wrap.
`timescale 1ns/1ps
module dmc_datapath
  import dmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [2:0] src_a_in,
  input wire logic [2:0] src_b_in,
  input wire logic [2:0] dst_in,
  input wire logic half_a_in,
  input wire logic half_b_in,
  input wire logic use_imm_in,
  input wire logic [15:0] imm_in,
  input wire logic signed_in,
  input wire logic rnd_in,
  input wire logic sat_in,
  input wire logic [1:0] mac_sel_in,
  output logic [31:0] result_out,
  output logic result_valid_out,
  output logic [1:0] flag_out,
  output logic [39:0] acc0_out,
  output logic [39:0] acc1_out
);

  // ==========================================================
  // Operand selection
  // ==========================================================
  logic [31:0] regs_r [DMC_NREG];
  logic [31:0] regs_nxt [DMC_NREG];
  logic [31:0] result_r, result_nxt;
  logic valid_r, valid_nxt;
  logic [1:0] flag_r, flag_nxt;
  logic [31:0] a32, b32;
  logic [15:0] ah, bh, ao, bo;

  always_comb
  begin
    a32 = regs_r[src_a_in]; // [RQ1] [RQ7]
    b32 = use_imm_in ? {{16{imm_in[15]}}, imm_in} : regs_r[src_b_in];
    ah = half_a_in ? a32[31:16] : a32[15:0]; // [RQ2]
    bh = half_b_in ? b32[31:16] : b32[15:0];
    ao = half_a_in ? a32[15:0] : a32[31:16];
    bo = half_b_in ? b32[15:0] : b32[31:16];
  end

  // ==========================================================
  // Video ALUs, one per byte lane
  // ==========================================================
  logic [31:0] vadd8, vavg8;
  logic [7:0] vdif [DMC_NVID];
  genvar g;
  generate
    for (g = 0; g < DMC_NVID; g++)
    begin : g_vid
      logic [7:0] x, y;
      logic [8:0] s;
      logic [9:0] t;
      assign x = a32[8*g +: 8];
      assign y = b32[8*g +: 8];
      assign s = {1'b0, x} + {1'b0, y};
      assign t = {1'b0, s} + 10'h001;
      assign vadd8[8*g +: 8] = s[8] ? 8'hff : s[7:0]; // [RQ6] [RQ10]
      assign vavg8[8*g +: 8] = t[8:1]; // [RQ10]
      assign vdif[g] = x >= y ? x - y : y - x;
    end
  endgenerate

  // ==========================================================
  // Multiply-accumulate units
  // ==========================================================
  logic mac_op, load_op;
  logic [15:0] mres0, mres1;
  assign mac_op = op_valid_in && (op_code_in == OP_MAC ||
                                  op_code_in == OP_MLOAD);
  assign load_op = op_code_in == OP_MLOAD;

  dmc_mac_unit u_mac0 (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .en_in(mac_op && mac_sel_in[0]), .load_in(load_op), // [RQ5]
    .signed_in(signed_in), .rnd_in(rnd_in), .sat_in(sat_in),
    .a_in(ah), .b_in(bh), .acc_out(acc0_out), .res16_out(mres0)
  );
  dmc_mac_unit u_mac1 (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .en_in(mac_op && mac_sel_in[1]), .load_in(load_op), // [RQ5]
    .signed_in(signed_in), .rnd_in(rnd_in), .sat_in(sat_in),
    .a_in(ao), .b_in(bo), .acc_out(acc1_out), .res16_out(mres1)
  );

  // ==========================================================
  // ALUs and shifter
  // ==========================================================
  function automatic logic [4:0] sign_bits(input logic [31:0] v);
    logic done;
    sign_bits = 5'h00;
    done = 1'b0;
    for (int i = 30; i >= 0; i--)
      if (!done && v[i] == v[31]) sign_bits = sign_bits + 5'h01;
      else done = 1'b1;
  endfunction : sign_bits

  logic [40:0] w33;
  logic [16:0] shi, slo;
  logic [31:0] dual, mask, dmask, dstep;
  logic [39:0] sh40;
  logic [5:0] amt;
  logic [9:0] absdiff_sum;
  logic wr_two;
  logic [31:0] second;

  always_comb
  begin
    regs_nxt = regs_r;
    result_nxt = result_r;
    flag_nxt = flag_r;
    valid_nxt = 1'b0;
    wr_two = 1'b0;
    second = 32'h0;
    w33 = 41'h0;
    shi = {ah[15], ah} + {bh[15], bh}; // [RQ12]
    slo = {ao[15], ao} + {bo[15], bo};
    if (op_code_in == OP_SUB || op_code_in == OP_QUAD)
    begin
      shi = {ah[15], ah} - {bh[15], bh};
      slo = {ao[15], ao} - {bo[15], bo};
    end
    dual = sat_in ? {dmc_sat16({{24{slo[16]}}, slo}), // [RQ16]
                     dmc_sat16({{24{shi[16]}}, shi})} : {slo[15:0], shi[15:0]};
    amt = b32[5:0];
    sh40 = amt[5] ? 40'($signed({{8{a32[31]}}, a32}) >>> (6'h0 - amt))
                  : {{8{a32[31]}}, a32} << amt; // [RQ14]
    mask = (32'h1 << imm_in[12:8]) - 32'h1;
    dmask = mask << imm_in[4:0];
    dstep = {a32[30:0], 1'b0};
    if (dstep[31:16] >= b32[15:0])
      dstep = {dstep[31:16] - b32[15:0], dstep[15:1], 1'b1};
    absdiff_sum = 10'(vdif[0]) + 10'(vdif[1]) + 10'(vdif[2]) +
                  10'(vdif[3]);
    case (op_code_in) // [RQ8] [RQ9] [RQ10] [RQ11]
      OP_ADD: w33 = {{9{a32[31]}}, a32} + {{9{b32[31]}}, b32};
      OP_SUB: w33 = {{9{a32[31]}}, a32} - {{9{b32[31]}}, b32};
      OP_AND: w33 = {9'h0, a32 & b32};
      OP_OR: w33 = {9'h0, a32 | b32};
      OP_XOR: w33 = {9'h0, a32 ^ b32};
      OP_ADD2: w33 = {9'h0, dual};
      OP_QUAD:
      begin
        w33 = {9'h0, dual};
        wr_two = 1'b1; // [RQ13]
        second = {16'(ao + bo), 16'(ah + bh)};
      end
      OP_POPC: w33 = 41'($countones(a32));
      OP_MUL32: w33 = {9'h0, 32'(a32 * b32)};
      OP_DIVS: w33 = {9'h0, dstep};
      OP_RND16: w33 = {25'h0, dmc_sat16(41'($signed(a32) +
                        $signed({1'b0, 16'h8000})) >>> 16)};
      OP_SIGNB: w33 = {36'h0, sign_bits(a32)};
      OP_NORM: w33 = {9'h0, a32 << sign_bits(a32)}; // [RQ14]
      OP_SHIFT: w33 = {sh40[39], sh40};
      OP_ROT: w33 = {9'h0, 32'({a32, a32} << b32[4:0] >> 32)};
      OP_EXTR: w33 = {9'h0, (a32 >> imm_in[4:0]) & mask};
      OP_DEP: w33 = {9'h0, (a32 & ~dmask) | ((b32 << imm_in[4:0]) & dmask)};
      OP_MIN, OP_MAX:
      begin
        flag_nxt = {1'b0, ($signed(a32) > $signed(b32)) ^
                           (op_code_in == OP_MIN)};
        w33 = {9'h0, flag_nxt[0] ? a32 : b32};
      end
      OP_VSRCH:
      begin
        flag_nxt = {$signed(ao) > $signed(bo), $signed(ah) > $signed(bh)};
        w33 = {9'h0, flag_nxt[1] ? ao : bo, flag_nxt[0] ? ah : bh};
      end
      OP_VADD8: w33 = {9'h0, vadd8};
      OP_VAVG8: w33 = {9'h0, vavg8};
      OP_ABSACC: w33 = {9'h0, regs_r[dst_in] + {22'h0, absdiff_sum}};
      OP_ALIGN: w33 = {9'h0, 32'({b32, a32} >> {imm_in[1:0], 3'h0})};
      OP_PACK: w33 = {9'h0, a32[23:16], a32[7:0], b32[23:16], b32[7:0]};
      OP_MREAD: w33 = {9'h0, mres1, mres0}; // [RQ4]
      default: w33 = 41'h0;
    endcase
    if (sat_in && (op_code_in == OP_ADD || op_code_in == OP_SUB))
      w33 = {9'h0, dmc_sat32(w33)}; // [RQ16]
    if (op_valid_in && !mac_op)
    begin
      valid_nxt = 1'b1;
      result_nxt = w33[31:0];
      regs_nxt[dst_in] = w33[31:0]; // [RQ15]
      if (wr_two) regs_nxt[dst_in ^ 3'h1] = second; // [RQ13]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < DMC_NREG; i++) regs_r[i] <= DMC_REG_RST;
      result_r <= 32'h0;
      valid_r <= 1'b0;
      flag_r <= 2'h0;
    end
    else
    begin
      regs_r <= regs_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign result_out = result_r;
  assign result_valid_out = valid_r;
  assign flag_out = flag_r;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_reg_writeback: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) op_valid_in && !mac_op |=>
    regs_r[$past(dst_in)] == result_out && result_valid_out) // [RQ15]
    else $error("result not written back to destination");
  chk_add_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_ADD && !sat_in |=>
    result_out == $past(a32) + $past(b32)) // [RQ8]
    else $error("32-bit add wrong");
  chk_dual_half: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_ADD2 && !sat_in |=>
    result_out[15:0] == 16'($past(ah) + $past(bh))) // [RQ12]
    else $error("low half add wrong");
  chk_quad_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_QUAD ##1 1'b1 |->
    regs_r[$past(dst_in) ^ 3'h1] == $past(second)) // [RQ13]
    else $error("second ALU result missing");
  chk_popcount: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_POPC |=>
    result_out == 32'($countones($past(a32)))) // [RQ9]
    else $error("population count wrong");
  chk_minmax_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_MAX |=>
    !($signed(result_out) < $signed($past(a32)))) // [RQ11]
    else $error("max selected the smaller value");
  chk_avg_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    op_valid_in && op_code_in == OP_VAVG8 |=> result_out[7:0] ==
    8'((9'($past(a32[7:0])) + 9'($past(b32[7:0])) + 9'h1) >> 1)) // [RQ10]
    else $error("byte average wrong");
  chk_dual_mac: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mac_op && mac_sel_in == 2'h3 && load_op && signed_in && !sat_in |=>
    acc1_out == 40'($signed($past(ao)) * $signed($past(bo)))) // [RQ5]
    else $error("second MAC did not run in parallel");

endmodule : dmc_datapath

// ### test/dmc_seq_model.sv
// Sequencer model that issues decoded operations to the datapath.
`timescale 1ns/1ps
module dmc_seq_model
(
  input wire logic clk_in,
  output logic valid_out,
  output logic [37:0] word_out
);
  // ==========================================================
  // Issue and idle
  // ==========================================================
  initial
  begin
    valid_out = 1'b0;
    word_out = 38'h0;
  end

  // Presents one operation; the datapath takes it at the next edge.
  task automatic issue(input logic [37:0] w);
    @(posedge clk_in);
    valid_out <= 1'b1;
    word_out <= w;
  endtask : issue

  // Presents no operation; the fields change so stale values show.
  task automatic idle();
    @(posedge clk_in);
    valid_out <= 1'b0;
    word_out <= ~word_out;
  endtask : idle
endmodule : dmc_seq_model

// ### test/testbench.sv
// Self-checking bench of the dual multiply-accumulate datapath.
`timescale 1ns/1ps
module testbench
  import dmc_pkg::*;
;
  // ==========================================================
  // Signals, instances and clock
  // ==========================================================
  logic clk_in;
  logic rst_n_in;
  logic v;
  logic rv;
  logic pend;
  logic ef;
  logic [37:0] w;
  logic [31:0] res;
  logic [1:0] fl;
  logic [39:0] a0;
  logic [39:0] a1;
  logic [39:0] e0;
  logic [39:0] e1;
  logic [31:0] rf [8];
  logic [32:0] q [$];
  int bad_count;
  int checks;
  localparam logic [4:0] ops_tbl [18] = '{OP_ADD, OP_SUB, OP_AND, OP_OR,
    OP_XOR, OP_ADD2, OP_QUAD, OP_POPC, OP_MUL32, OP_MIN, OP_MAX, OP_SHIFT,
    OP_ROT, OP_VADD8, OP_ABSACC, OP_MLOAD, OP_MAC, OP_MREAD};

  dmc_seq_model dmc_seq_model_i (.clk_in(clk_in), .valid_out(v),
    .word_out(w));

  dmc_datapath dmc_datapath_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .op_valid_in(v),
    .op_code_in(w[37:33]), .src_a_in(w[32:30]), .src_b_in(w[29:27]),
    .dst_in(w[26:24]), .half_a_in(w[6]), .half_b_in(w[5]),
    .use_imm_in(w[23]), .imm_in(w[22:7]), .signed_in(w[4]), .rnd_in(w[3]),
    .sat_in(w[2]), .mac_sel_in(w[1:0]), .result_out(res),
    .result_valid_out(rv), .flag_out(fl), .acc0_out(a0), .acc1_out(a1));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ==========================================================
  // Compare tasks, monitor and reference
  // ==========================================================
  task automatic cmp_val(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask : cmp_bit

  always @(posedge clk_in)
    pend <= v && w[37:33] != OP_MAC && w[37:33] != OP_MLOAD && rst_n_in;

  always @(negedge clk_in)
    if (rst_n_in)
    begin
      cmp_bit(rv, pend);
      if (pend && q.size() > 0)
      begin
        cmp_val({8'h0, res}, {8'h0, q[0][31:0]});
        cmp_bit(fl[0], q[0][32]);
        q.delete(0);
      end
    end

  function automatic logic [39:0] sx(input logic [15:0] h, input logic s);
    return s ? {{24{h[15]}}, h} : {24'h0, h};
  endfunction : sx

  function automatic logic [15:0] rd(input logic [39:0] e, input logic n);
    logic [39:0] t;
    t = n ? e + 40'h8000 : e;
    return t[31:16];
  endfunction : rd

  task automatic run(input logic [4:0] o, input logic [2:0] a,
    input logic [2:0] b, input logic [2:0] d, input logic u,
    input logic [15:0] im, input logic [6:0] m);
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic signed [31:0] sv;
    logic [15:0] pa;
    logic [15:0] pb;
    logic [15:0] qa;
    logic [15:0] qb;
    x = rf[a];
    sv = x;
    y = u ? {{16{im[15]}}, im} : rf[b];
    pa = m[6] ? x[31:16] : x[15:0];
    qa = m[6] ? x[15:0] : x[31:16];
    pb = m[5] ? y[31:16] : y[15:0];
    qb = m[5] ? y[15:0] : y[31:16];
    r = 32'h0;
    case (o)
      OP_ADD: r = x + y;
      OP_SUB: r = x - y;
      OP_AND: r = x & y;
      OP_OR: r = x | y;
      OP_XOR: r = x ^ y;
      OP_ADD2: r = {qa + qb, pa + pb};
      OP_QUAD: r = {qa - qb, pa - pb};
      OP_POPC: r = 32'($countones(x));
      OP_MUL32: r = x * y;
      OP_ROT: r = (x << y[4:0]) | (x >> (6'd32 - y[4:0]));
      OP_MREAD: r = {rd(e1, m[3]), rd(e0, m[3])};
      OP_MIN, OP_MAX:
      begin
        ef = ($signed(x) > $signed(y)) ^ (o == OP_MIN);
        r = ef ? x : y;
      end
      OP_SHIFT:
        if (y[5]) r = sv >>> (6'd0 - y[5:0]);
        else r = x << y[5:0];
      OP_VADD8:
        for (int i = 0; i < 32; i += 8)
          r[i+:8] = (x[i+:8] + 9'h0 + y[i+:8]) > 9'hff ? 8'hff
            : x[i+:8] + y[i+:8];
      OP_ABSACC:
      begin
        r = rf[d];
        for (int i = 0; i < 32; i += 8)
          r += (x[i+:8] > y[i+:8]) ? x[i+:8] - y[i+:8] : y[i+:8] - x[i+:8];
      end
      default: r = 32'h0;
    endcase
    if (m[2] && (o == OP_ADD || o == OP_SUB) && r[31] != x[31]
        && (x[31] ^ y[31]) == (o == OP_SUB))
      r = x[31] ? 32'h8000_0000 : 32'h7fff_ffff;
    if (o == OP_MLOAD || o == OP_MAC)
    begin
      if (m[0]) e0 = sx(pa, m[4]) * sx(pb, m[4]) + (o == OP_MAC ? e0 : 40'h0);
      if (m[1]) e1 = sx(qa, m[4]) * sx(qb, m[4]) + (o == OP_MAC ? e1 : 40'h0);
    end
    else
    begin
      rf[d] = r;
      if (o == OP_QUAD) rf[d ^ 3'h1] = {qa + qb, pa + pb};
      q.push_back({ef, r});
    end
    dmc_seq_model_i.issue({o, a, b, d, u, im, m});
  endtask : run

  // ==========================================================
  // Sequences and verdict
  // ==========================================================
  task automatic load(input logic [2:0] d, input logic [31:0] val);
    run(OP_AND, d, d, d, 1'b1, 16'h0, 7'h00);
    run(OP_ADD, d, d, d, 1'b1, val[31:16] + val[15], 7'h00);
    run(OP_SHIFT, d, d, d, 1'b1, 16'h0010, 7'h00);
    run(OP_ADD, d, d, d, 1'b1, val[15:0], 7'h00);
  endtask : load

  task automatic flush(input string t);
    repeat (3) dmc_seq_model_i.idle();
    @(negedge clk_in);
    cmp_val(a0, e0);
    cmp_val(a1, e1);
    cmp_val(40'(q.size()), 40'h0);
    $display("test %s done", t);
  endtask : flush

  task automatic do_reset();
    dmc_seq_model_i.idle();
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    cmp_val(a0 | a1 | {8'h0, res}, 40'h0);
    cmp_bit(rv | fl[0], 1'b0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (rf[i]) rf[i] = 32'h0;
    e0 = 40'h0;
    e1 = 40'h0;
    ef = 1'b0;
  endtask : do_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    rst_n_in = 1'b0;
    bad_count = 0;
    checks = 0;
    void'($urandom(32'ha77bb42d));
    do_reset();
    for (int i = 0; i < 8; i++)
      load(3'(i), $urandom());
    flush("load");
    load(3'h1, 32'h7fff_ffff);
    load(3'h2, 32'h0000_0001);
    load(3'h3, 32'h8000_0000);
    run(OP_ADD, 3'h1, 3'h2, 3'h4, 1'b0, 16'h0, 7'h04);
    run(OP_SUB, 3'h3, 3'h2, 3'h5, 1'b0, 16'h0, 7'h04);
    run(OP_ADD, 3'h1, 3'h2, 3'h6, 1'b0, 16'h0, 7'h00);
    run(OP_ADD2, 3'h1, 3'h1, 3'h7, 1'b0, 16'h0, 7'h40);
    run(OP_QUAD, 3'h7, 3'h3, 3'h0, 1'b0, 16'h0, 7'h20);
    run(OP_OR, 3'h1, 3'h1, 3'h1, 1'b0, 16'h0, 7'h00);
    run(OP_MLOAD, 3'h3, 3'h1, 3'h0, 1'b0, 16'h0, 7'h13);
    run(OP_MAC, 3'h3, 3'h3, 3'h0, 1'b0, 16'h0, 7'h02);
    run(OP_MREAD, 3'h0, 3'h0, 3'h2, 1'b0, 16'h0, 7'h08);
    flush("corner");
    for (int n = 0; n < 400; n++)
      run(ops_tbl[$urandom_range(0, 17)], 3'($urandom()), 3'($urandom()),
        3'($urandom()), 1'($urandom()), 16'($urandom()),
        7'($urandom()) & 7'h7b);
    flush("random");
    do_reset();
    flush("reset");
    report_and_stop();
  end
endmodule : testbench
